// ===== hdl/rcf_flags.sv
// Reset-cause and wake-cause flag register with AXI4-Lite access and interrupt
//
// Added by the designer: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/100ps
module rcf_flags
(
   // Clock and reset
   input  wire logic        clk_sys_in,
   input  wire logic        arst_n_in,
   // Event inputs, one-cycle pulses or levels on clk_sys_in
   input  wire logic        ddr_supply_overvoltage_in,
   input  wire logic        primary_config_error_in,
   input  wire logic        config_failure_in,
   input  wire logic        config_error_clear_in,
   input  wire logic        battery_domain_poweron_in,
   input  wire logic        battery_exit_in,
   input  wire logic        deep_sleep_in,
   input  wire logic        config_mismatch_reset_in,
   input  wire logic        master_clear_pin_in,
   input  wire logic        software_reset_in,
   input  wire logic        deadman_timer_in,
   input  wire logic        watchdog_timeout_in,
   input  wire logic        sleep_wake_in,
   input  wire logic        idle_wake_in,
   input  wire logic        brownout_in,
   input  wire logic        poweron_in,
   // AXI4-Lite write address
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [3:0]  s_axi_awaddr,
   // AXI4-Lite write data
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   // AXI4-Lite write response
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   output logic [1:0]       s_axi_bresp,
   // AXI4-Lite read address
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   input  wire logic [3:0]  s_axi_araddr,
   // AXI4-Lite read data
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   // Interrupt
   output logic             irq_out
);

   // ==========================================================================
   // Event vector
   // ==========================================================================
   logic [31:0] set_vec;
   logic [31:0] cause_q;
   logic [31:0] mask_q;

   always_comb
   begin
      set_vec = 32'h0000_0000;
      set_vec[rcf_pkg::RCF_HVD_BIT]     = ddr_supply_overvoltage_in;
      set_vec[rcf_pkg::RCF_CFGERR_BIT]  = primary_config_error_in;
      set_vec[rcf_pkg::RCF_CFGFAIL_BIT] = config_failure_in;
      set_vec[rcf_pkg::RCF_BATPOR_BIT]  = battery_domain_poweron_in;
      set_vec[rcf_pkg::RCF_VBEXIT_BIT]  = battery_exit_in;
      set_vec[rcf_pkg::RCF_DSLP_BIT]    = deep_sleep_in;
      set_vec[rcf_pkg::RCF_CFGMIS_BIT]  = config_mismatch_reset_in;
      set_vec[rcf_pkg::RCF_EXT_BIT]     = master_clear_pin_in;
      set_vec[rcf_pkg::RCF_SW_BIT]      = software_reset_in;
      set_vec[rcf_pkg::RCF_DEADMAN_BIT] = deadman_timer_in;
      set_vec[rcf_pkg::RCF_WDOG_BIT]    = watchdog_timeout_in;
      set_vec[rcf_pkg::RCF_SLEEP_BIT]   = sleep_wake_in;
      set_vec[rcf_pkg::RCF_IDLE_BIT]    = idle_wake_in;
      set_vec[rcf_pkg::RCF_BO_BIT]      = brownout_in;
      set_vec[rcf_pkg::RCF_POR_BIT]     = poweron_in;
   end

   // ==========================================================================
   // AXI4-Lite write path
   // ==========================================================================
   logic        aw_held_q;
   logic        w_held_q;
   logic [3:0]  awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0]  wstrb_q;
   logic        wr_go;
   logic [31:0] wr_bits;

   // Accept each channel once; hold until the response is taken
   assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
   assign s_axi_wready  = !w_held_q && !s_axi_bvalid;
   assign wr_go         = aw_held_q && w_held_q && !s_axi_bvalid;

   always_comb
   begin
      wr_bits = 32'h0000_0000;
      for (int i = 0; i < 4; i++)
      begin
         if (wstrb_q[i])
         begin
            wr_bits[i*8 +: 8] = wdata_q[i*8 +: 8];
         end
      end
   end

   always_ff @(posedge clk_sys_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         aw_held_q <= 1'b0;
         awaddr_q  <= 4'h0;
      end
      else if (s_axi_awvalid && s_axi_awready)
      begin
         aw_held_q <= 1'b1;
         awaddr_q  <= s_axi_awaddr;
      end
      else if (wr_go)
      begin
         aw_held_q <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         w_held_q <= 1'b0;
         wdata_q  <= 32'h0000_0000;
         wstrb_q  <= 4'h0;
      end
      else if (s_axi_wvalid && s_axi_wready)
      begin
         w_held_q <= 1'b1;
         wdata_q  <= s_axi_wdata;
         wstrb_q  <= s_axi_wstrb;
      end
      else if (wr_go)
      begin
         w_held_q <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= rcf_pkg::RCF_RESP_OKAY;
      end
      else if (wr_go)
      begin
         s_axi_bvalid <= 1'b1;
         if (awaddr_q == rcf_pkg::RCF_CAUSE_OFFS || awaddr_q == rcf_pkg::RCF_MASK_OFFS ||
             awaddr_q == rcf_pkg::RCF_IRQST_OFFS)
         begin
            s_axi_bresp <= rcf_pkg::RCF_RESP_OKAY;
         end
         else
         begin
            s_axi_bresp <= rcf_pkg::RCF_RESP_SLVERR;
         end
      end
      else if (s_axi_bready)
      begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // ==========================================================================
   // Cause register
   // ==========================================================================
   logic wr_cause;
   logic wr_w1c;

   assign wr_cause = wr_go && (awaddr_q == rcf_pkg::RCF_CAUSE_OFFS);
   assign wr_w1c   = wr_go && (awaddr_q == rcf_pkg::RCF_IRQST_OFFS);

   // Per-bit update; a hardware set wins over any software write or clear
   generate
      for (genvar b = 0; b < 32; b++)
      begin : g_flag
         if (rcf_pkg::RCF_IMPL_MASK[b])
         begin : g_impl
            always_ff @(posedge clk_sys_in or negedge arst_n_in)
            begin
               if (!arst_n_in)
               begin
                  cause_q[b] <= rcf_pkg::RCF_CAUSE_RST[b];
               end
               else if (set_vec[b])
               begin
                  cause_q[b] <= 1'b1;
               end
               else if (rcf_pkg::RCF_HWCLR_MASK[b] && config_error_clear_in)
               begin
                  cause_q[b] <= 1'b0;
               end
               else if (wr_cause && wstrb_q[b/8])
               begin
                  cause_q[b] <= wdata_q[b];
               end
               else if (wr_w1c && wr_bits[b])
               begin
                  cause_q[b] <= 1'b0;
               end
            end
         end
         else
         begin : g_unimpl
            assign cause_q[b] = 1'b0;
         end
      end
   endgenerate

   // ==========================================================================
   // Interrupt mask
   // ==========================================================================
   always_ff @(posedge clk_sys_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         mask_q <= rcf_pkg::RCF_MASK_RST;
      end
      else if (wr_go && awaddr_q == rcf_pkg::RCF_MASK_OFFS)
      begin
         for (int i = 0; i < 4; i++)
         begin
            if (wstrb_q[i])
            begin
               mask_q[i*8 +: 8] <= wdata_q[i*8 +: 8] & rcf_pkg::RCF_IMPL_MASK[i*8 +: 8];
            end
         end
      end
   end

   assign irq_out = |(cause_q & mask_q);

   // ==========================================================================
   // AXI4-Lite read path
   // ==========================================================================
   assign s_axi_arready = !s_axi_rvalid;

   always_ff @(posedge clk_sys_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= rcf_pkg::RCF_RESP_OKAY;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= rcf_pkg::RCF_RESP_OKAY;
         if (s_axi_araddr == rcf_pkg::RCF_CAUSE_OFFS || s_axi_araddr == rcf_pkg::RCF_IRQST_OFFS)
         begin
            s_axi_rdata <= cause_q & rcf_pkg::RCF_IMPL_MASK;
         end
         else if (s_axi_araddr == rcf_pkg::RCF_MASK_OFFS)
         begin
            s_axi_rdata <= mask_q;
         end
         else
         begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= rcf_pkg::RCF_RESP_SLVERR;
         end
      end
      else if (s_axi_rready)
      begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // ==========================================================================
   // Assertions
   // ==========================================================================
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (!arst_n_in);

   a_hvd_sets_flag: assert property (ddr_supply_overvoltage_in |=> cause_q[29])
      else $error("over-voltage flag not set");
   a_cfgerr_sets: assert property (primary_config_error_in |=> cause_q[27])
      else $error("config error flag not set");
   a_cfgfail_sets: assert property (config_failure_in |=> cause_q[26])
      else $error("config failure flag not set");
   a_batpor_sets: assert property (battery_domain_poweron_in |=> cause_q[17])
      else $error("battery poweron flag not set");
   a_vbexit_sets: assert property (battery_exit_in |=> cause_q[16])
      else $error("battery exit flag not set");
   a_dslp_sets: assert property (deep_sleep_in |=> cause_q[10])
      else $error("deep sleep flag not set");
   a_mismatch_sets: assert property (config_mismatch_reset_in |=> cause_q[9])
      else $error("mismatch flag not set");
   a_ext_sets: assert property (master_clear_pin_in |=> cause_q[7])
      else $error("external reset flag not set");
   a_sw_sets: assert property (software_reset_in |=> cause_q[6])
      else $error("software reset flag not set");
   a_deadman_sets: assert property (deadman_timer_in |=> cause_q[5])
      else $error("deadman flag not set");
   a_wdt_sets: assert property (watchdog_timeout_in |=> cause_q[4])
      else $error("watchdog flag not set");
   a_wake_sets: assert property (sleep_wake_in ##0 idle_wake_in |=> cause_q[3] && cause_q[2])
      else $error("wake flags not set");
   a_bo_por_sets: assert property (brownout_in || poweron_in |=> (cause_q[1] || !$past(brownout_in)) &&
                                   (cause_q[0] || !$past(poweron_in)))
      else $error("brownout or poweron flag not set");
   a_sticky_flags: assert property (cause_q[0] && !wr_cause && !wr_w1c |=> cause_q[0])
      else $error("poweron flag dropped without software");
   a_unimpl_zero: assert property (s_axi_rvalid |-> (s_axi_rdata & ~rcf_pkg::RCF_IMPL_MASK) == 32'h0)
      else $error("unimplemented bit set");
   a_hw_clear: assert property (config_error_clear_in && !primary_config_error_in |=> !cause_q[27])
      else $error("config error flag not cleared");
   a_no_side_clear: assert property (|set_vec && !wr_cause && !wr_w1c && !config_error_clear_in
                                     |=> (cause_q & $past(cause_q)) == $past(cause_q))
      else $error("set event cleared another flag");
   a_irq_level: assert property (wr_w1c && (&wr_bits) && !(|set_vec) |=> !irq_out)
      else $error("interrupt still high after full clear");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read not answered");

   c_por_clear: cover property (wr_w1c && wr_bits[0] ##1 !cause_q[0]);
   c_irq_rise: cover property (!irq_out ##1 irq_out);
   c_set_and_clear: cover property (wr_w1c && |(wr_bits & set_vec));
   c_bad_read: cover property (s_axi_rvalid && s_axi_rresp == rcf_pkg::RCF_RESP_SLVERR);

endmodule : rcf_flags

// ===== hdl/rcf_pkg.sv
// Package of register offsets, field positions and reset values for the reset-cause flags block
package rcf_pkg;

   // ==========================================================================
   // Register map (byte addresses)
   // ==========================================================================
   localparam logic [3:0] RCF_CAUSE_OFFS = 4'h0;
   localparam logic [3:0] RCF_MASK_OFFS  = 4'h4;
   localparam logic [3:0] RCF_IRQST_OFFS = 4'h8;

   // ==========================================================================
   // Flag positions in the cause register
   // ==========================================================================
   localparam int RCF_HVD_BIT    = 29;
   localparam int RCF_CFGERR_BIT = 27;
   localparam int RCF_CFGFAIL_BIT = 26;
   localparam int RCF_BATPOR_BIT = 17;
   localparam int RCF_VBEXIT_BIT = 16;
   localparam int RCF_DSLP_BIT   = 10;
   localparam int RCF_CFGMIS_BIT = 9;
   localparam int RCF_EXT_BIT    = 7;
   localparam int RCF_SW_BIT     = 6;
   localparam int RCF_DEADMAN_BIT = 5;
   localparam int RCF_WDOG_BIT   = 4;
   localparam int RCF_SLEEP_BIT  = 3;
   localparam int RCF_IDLE_BIT   = 2;
   localparam int RCF_BO_BIT     = 1;
   localparam int RCF_POR_BIT    = 0;

   // ==========================================================================
   // Masks and reset values
   // ==========================================================================
   localparam logic [31:0] RCF_IMPL_MASK  = 32'h2c03_06ff;
   localparam logic [31:0] RCF_HWCLR_MASK = 32'h0c00_0000;
   localparam logic [31:0] RCF_CAUSE_RST  = 32'h0003_0003;
   localparam logic [31:0] RCF_MASK_RST   = 32'h0000_0000;
   localparam logic [1:0]  RCF_RESP_OKAY   = 2'b00;
   localparam logic [1:0]  RCF_RESP_SLVERR = 2'b10;

endpackage : rcf_pkg

// ===== testbench/tb.sv
// Self-checking bench for the reset-cause flag register
`timescale 1ns/100ps
module tb;
   // ==========================================================================
   // Clock, reset and stimulus
   // ==========================================================================
   logic        clk_sys_in = 1'b0;
   logic        arst_n_in  = 1'b0;
   logic [14:0] ev = '0;
   logic        clr = 1'b0;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [3:0]  awaddr = '0, araddr = '0, wstrb = '0;
   logic [31:0] wdata = '0, x = 32'd13590, r, s;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq_out;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   logic [31:0] cause_m, mask_m;
   int          err_total = 0, total_checks = 0;
   // Event index to flag position, same order as the vector below
   int          pos [15] = '{0, 1, 2, 3, 4, 5, 6, 7, 9, 10, 16, 17, 26, 27, 29};
   always #20 clk_sys_in = ~clk_sys_in;
   rcf_flags u_rcf_flags (
      .clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in),
      .poweron_in(ev[0]), .brownout_in(ev[1]), .idle_wake_in(ev[2]), .sleep_wake_in(ev[3]),
      .watchdog_timeout_in(ev[4]), .deadman_timer_in(ev[5]), .software_reset_in(ev[6]),
      .master_clear_pin_in(ev[7]), .config_mismatch_reset_in(ev[8]), .deep_sleep_in(ev[9]),
      .battery_exit_in(ev[10]), .battery_domain_poweron_in(ev[11]), .config_failure_in(ev[12]),
      .primary_config_error_in(ev[13]), .ddr_supply_overvoltage_in(ev[14]), .config_error_clear_in(clr),
      .s_axi_awvalid(awvalid), .s_axi_awready(s_axi_awready), .s_axi_awaddr(awaddr),
      .s_axi_wvalid(wvalid), .s_axi_wready(s_axi_wready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(bready), .s_axi_bresp(s_axi_bresp),
      .s_axi_arvalid(arvalid), .s_axi_arready(s_axi_arready), .s_axi_araddr(araddr),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(rready), .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp), .irq_out(irq_out));
   // ==========================================================================
   // Helpers
   // ==========================================================================
   function automatic logic [31:0] xs();
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      x = x ^ (x << 5);
      return x;
   endfunction : xs
   function automatic logic [31:0] bm(input logic [3:0] s);
      return {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
   endfunction : bm
   function automatic logic [1:0] resp_of(input logic [3:0] a);
      return (a == 4'h0 || a == 4'h4 || a == 4'h8) ? 2'b00 : 2'b10;
   endfunction : resp_of
   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk
   task automatic end_sim();
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : end_sim
   // ==========================================================================
   // Bus master and event pulse tasks, entered just after a rising edge
   // ==========================================================================
   task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
      int n;
      n = 0;
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do
      begin
         @(posedge clk_sys_in);
         n++;
         if (awvalid && s_axi_awready) awvalid <= 1'b0;
         if (wvalid && s_axi_wready) wvalid <= 1'b0;
      end
      while (!s_axi_bvalid && n < 40);
      if (n >= 40) chk("write wait", 32'h1, 32'h0);
      chk("bresp", {30'h0, s_axi_bresp}, {30'h0, resp_of(a)});
      bready <= 1'b0;
      case (a)
         4'h0: cause_m = (cause_m & ~bm(s)) | (d & bm(s) & 32'h2c03_06ff);
         4'h4: mask_m = (mask_m & ~bm(s)) | (d & bm(s) & 32'h2c03_06ff);
         4'h8: cause_m = cause_m & ~(d & bm(s));
         default: ;
      endcase
      @(posedge clk_sys_in);
   endtask : wr
   task automatic rd(input logic [3:0] a);
      int n;
      n = 0;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do
      begin
         @(posedge clk_sys_in);
         n++;
         if (arvalid && s_axi_arready) arvalid <= 1'b0;
      end
      while (!s_axi_rvalid && n < 40);
      if (n >= 40) chk("read wait", 32'h1, 32'h0);
      chk("rresp", {30'h0, s_axi_rresp}, {30'h0, resp_of(a)});
      chk("rdata", s_axi_rdata, (a == 4'h4) ? mask_m : (a == 4'h0 || a == 4'h8) ? cause_m : 32'h0);
      rready <= 1'b0;
      @(posedge clk_sys_in);
      chk("irq", {31'h0, irq_out}, {31'h0, |(cause_m & mask_m)});
   endtask : rd
   task automatic pulse(input logic [14:0] v, input logic c);
      ev <= v;
      clr <= c;
      @(posedge clk_sys_in);
      ev <= '0;
      clr <= 1'b0;
      if (c) cause_m = cause_m & ~32'h0c00_0000;
      for (int i = 0; i < 15; i++)
         if (v[i]) cause_m[pos[i]] = 1'b1;
      @(posedge clk_sys_in);
   endtask : pulse
   // ==========================================================================
   // Scenarios
   // ==========================================================================
   initial
   begin
      repeat (20000) @(posedge clk_sys_in);
      err_total++;
      end_sim();
   end
   initial
   begin
      cause_m = 32'h0003_0003;
      mask_m = 32'h0;
      repeat (20) @(posedge clk_sys_in);
      arst_n_in <= 1'b1;
      @(posedge clk_sys_in);
      rd(4'h0);
      rd(4'h4);
      wr(4'h8, 32'hffff_ffff, 4'hf);
      rd(4'h0);
      for (int i = 0; i < 15; i++)
      begin
         pulse(15'h1 << i, 1'b0);
         rd(4'h0);
      end
      repeat (10) @(posedge clk_sys_in);
      rd(4'h8);
      wr(4'h8, 32'h0000_0403, 4'hf);
      rd(4'h0);
      pulse(15'h0203, 1'b0);
      rd(4'h0);
      pulse(15'h0, 1'b1);
      rd(4'h0);
      pulse(15'h2000, 1'b1);
      rd(4'h0);
      wr(4'h0, 32'hffff_ffff, 4'hf);
      rd(4'h0);
      for (int k = 0; k < 24; k++)
      begin
         r = xs();
         s = xs();
         wr(4'h0, r, s[3:0]);
         rd(4'h8);
         r = xs();
         pulse(r[14:0], r[15]);
         rd(4'h0);
         wr(4'h4, xs(), 4'hf);
         rd(4'h4);
         r = xs();
         s = xs();
         wr(4'h8, r, s[3:0]);
         rd(4'h8);
      end
      wr(4'h4, 32'h0000_0001, 4'h1);
      wr(4'h8, 32'hffff_ffff, 4'hf);
      rd(4'h0);
      pulse(15'h0001, 1'b0);
      rd(4'h0);
      wr(4'h8, 32'h0000_0001, 4'h1);
      rd(4'h0);
      wr(4'hc, 32'hffff_ffff, 4'hf);
      rd(4'hc);
      rd(4'h0);
      end_sim();
   end
endmodule : tb
